// ### dv/test_ursf_status_flags.sv
// testbench for the receive status and interrupt flags
`timescale 1ns/1ps
module test_ursf_status_flags;
  logic clk_sys, nrst, reg_wr, reg_rd, multidrop_mode, special_char_mode;
  logic parity_enable, parity_odd, char_tick, rx_valid, rx_break, queue_full;
  logic queue_empty, queue_pop, queue_push, clock_settled, send, send_brk;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] stale_data_limit, rx_flow_match, send_flow;
  logic [11:0] queue_push_word;
  logic [15:0] gpio_in;
  logic [2:0] main_irq_status;
  ursf_pkg::ursf_rx_char_t rx_char, send_char;
  ursf_pkg::ursf_char_stat_t queue_pop_stat;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] a_row [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h40};
  logic [7:0] m_row [7] = '{8'h3F, 8'h00, 8'h3F, 8'h00, 8'h2F, 8'h00, 8'h00};
  logic [13:0] c_row [7] = '{14'h0040, 14'h00C0, 14'h00C0, 14'h00C8, 14'h00C2,
                             14'h1560, 14'h1550};
  logic [11:0] w_row [7] = '{12'h011, 12'h030, 12'h031, 12'h038, 12'h032, 12'h551, 12'h550};
  logic [7:0] l_row [7] = '{8'h04, 8'h00, 8'h04, 8'h20, 8'h08, 8'h04, 8'h00};
  logic [6:0] odd_row = 7'h04;
  logic [6:0] md_row = 7'h60;
  // uart 1 so that pin ownership is not the trivial low nibble
  ursf_status_flags #(.UART_INDEX(1), .NUM_GPIO(16), .STALE_WIDTH(4)) uut (.*);
  ursf_far_model #(.DEPTH(2)) far (.*);
  initial clk_sys = 1'h0;
  always #50 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // all tasks start and end on a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge clk_sys);
    reg_wr = 1'h0;
    @(negedge clk_sys);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge clk_sys);
    reg_rd = 1'h0;
    check({4'h0, reg_rdata}, {4'h0, exp});
    @(negedge clk_sys);
  endtask
  task automatic mainchk(input logic [2:0] exp);
    check({9'h000, main_irq_status}, {9'h000, exp});
  endtask
  // returns once main status has had its extra cycle
  task automatic ev(input logic brk, input logic [13:0] c, input logic [3:0] fl,
                    input logic ep, input logic [11:0] ew);
    send = ~brk;
    send_brk = brk;
    send_char = c;
    send_flow = fl;
    @(negedge clk_sys);
    send = 1'h0;
    send_brk = 1'h0;
    @(negedge clk_sys);
    check({11'h000, queue_push}, {11'h000, ep});
    if (ep) check(queue_push_word, ew);
    @(negedge clk_sys);
  endtask
  task automatic pop();
    queue_pop = 1'h1;
    @(negedge clk_sys);
    queue_pop = 1'h0;
    @(negedge clk_sys);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      char_tick = 1'h1;
      @(negedge clk_sys);
      char_tick = 1'h0;
      @(negedge clk_sys);
    end
  endtask
  task automatic flip(input int p);
    gpio_in[p] = ~gpio_in[p];
    repeat (3) @(negedge clk_sys);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, multidrop_mode, special_char_mode} = '0;
    {parity_enable, parity_odd, stale_data_limit, char_tick, queue_pop} = '0;
    {clock_settled, gpio_in, send, send_brk, send_char, send_flow} = '0;
    nrst = 1'h0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'h1;
    @(negedge clk_sys);
    parity_enable = 1'h1;
    for (int i = 0; i < 7; i++) begin
      parity_odd = odd_row[i];
      multidrop_mode = md_row[i];
      ev(1'h0, c_row[i], 4'h0, 1'h1, w_row[i]);
      pop();
      rdchk(8'h04, l_row[i]);
      $display("character row %0d done", i);
    end
    {parity_enable, multidrop_mode} = '0;
    rdchk(8'h06, 8'h20);
    for (int i = 0; i < 7; i++) begin
      rdchk(a_row[i], 8'h00);
      wr(a_row[i], 8'hFF);
      rdchk(a_row[i], m_row[i]);
      wr(a_row[i], 8'h00);
    end
    $display("register table done");
    wr(8'h05, 8'h10);
    wr(8'h03, 8'h10);
    ev(1'h1, 14'h0000, 4'h0, 1'h1, 12'h004);
    mainchk(3'h2);
    rdchk(8'h06, 8'h10);
    rdchk(8'h06, 8'h00);
    ev(1'h0, 14'h0000, 4'h0, 1'h1, 12'h000);
    pop();
    rdchk(8'h04, 8'h10);
    rdchk(8'h04, 8'h10);
    mainchk(3'h1);
    pop();
    rdchk(8'h04, 8'h00);
    $display("break test done");
    special_char_mode = 1'h1;
    for (int i = 0; i < 4; i++) begin
      ev(1'h0, 14'h0440, 4'h1 << i, 1'h1, 12'h110);
      pop();
      rdchk(8'h06, 8'h01 << i);
    end
    wr(8'h05, 8'h02);
    ev(1'h0, 14'h0440, 4'h1, 1'h1, 12'h110);
    mainchk(3'h0);
    wr(8'h05, 8'h01);
    mainchk(3'h2);
    pop();
    rdchk(8'h06, 8'h01);
    special_char_mode = 1'h0;
    ev(1'h0, 14'h0440, 4'hF, 1'h1, 12'h110);
    pop();
    rdchk(8'h06, 8'h00);
    $display("special character test done");
    ev(1'h0, 14'h00C0, 4'h0, 1'h1, 12'h030);
    ev(1'h0, 14'h00C0, 4'h0, 1'h1, 12'h030);
    ev(1'h0, 14'h00C0, 4'h0, 1'h0, 12'h000);
    rdchk(8'h04, 8'h02);
    pop();
    pop();
    rdchk(8'h04, 8'h00);
    $display("overrun test done");
    wr(8'h03, 8'h01);
    stale_data_limit = 4'h3;
    ev(1'h0, 14'h00C0, 4'h0, 1'h1, 12'h030);
    tick(3);
    rdchk(8'h04, 8'h00);
    tick(1);
    rdchk(8'h04, 8'h01);
    mainchk(3'h1);
    ev(1'h0, 14'h00C0, 4'h0, 1'h1, 12'h030);
    rdchk(8'h04, 8'h00);
    tick(3);
    rdchk(8'h04, 8'h00);
    pop();
    tick(3);
    rdchk(8'h04, 8'h00);
    stale_data_limit = 4'h0;
    tick(6);
    rdchk(8'h04, 8'h00);
    pop();
    $display("stale data test done");
    flip(0);
    rdchk(8'h08, 8'h00);
    flip(4);
    rdchk(8'h08, 8'h01);
    rdchk(8'h08, 8'h00);
    wr(8'h07, 8'h02);
    flip(4);
    mainchk(3'h0);
    flip(5);
    mainchk(3'h4);
    rdchk(8'h08, 8'h03);
    clock_settled = 1'h1;
    wr(8'h07, 8'h00);
    repeat (2) @(negedge clk_sys);
    rdchk(8'h08, 8'h20);
    rdchk(8'h08, 8'h20);
    mainchk(3'h0);
    wr(8'h07, 8'h20);
    repeat (2) @(negedge clk_sys);
    mainchk(3'h4);
    clock_settled = 1'h0;
    repeat (3) @(negedge clk_sys);
    rdchk(8'h08, 8'h00);
    nrst = 1'h0;
    @(negedge clk_sys);
    nrst = 1'h1;
    @(negedge clk_sys);
    rdchk(8'h07, 8'h00);
    $display("status and reset test done");
    report_and_stop();
  end
endmodule

// ### dv/ursf_far_model.sv
// far side model: receiver event source and a shallow receive queue
`timescale 1ns/1ps
module ursf_far_model #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // requests from the bench
  input  wire logic                      send,
  input  wire logic                      send_brk,
  input  wire ursf_pkg::ursf_rx_char_t   send_char,
  input  wire logic [3:0]                send_flow,
  input  wire logic                      queue_pop,
  // receiver events
  output logic                           rx_valid,
  output logic                           rx_break,
  output ursf_pkg::ursf_rx_char_t        rx_char,
  output logic [3:0]                     rx_flow_match,
  // queue
  input  wire logic                      queue_push,
  input  wire logic [11:0]               queue_push_word,
  output logic                           queue_full,
  output logic                           queue_empty,
  output ursf_pkg::ursf_char_stat_t      queue_pop_stat
);
  ursf_pkg::ursf_char_stat_t mem [DEPTH];
  int   count;
  int   rd_ptr;
  int   wr_ptr;
  logic push_ok;
  logic pop_ok;
  assign push_ok = queue_push && (count < DEPTH);
  assign pop_ok  = queue_pop && (count > 0);
  // idle bus toggles so a stale value never passes for a fresh one
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_valid      <= 1'h0;
      rx_break      <= 1'h0;
      rx_char       <= '0;
      rx_flow_match <= 4'h0;
    end else begin
      rx_valid      <= send;
      rx_break      <= send_brk;
      rx_char       <= send ? send_char : ~rx_char;
      rx_flow_match <= send ? send_flow : ~rx_flow_match;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count  <= 0;
      rd_ptr <= 0;
      wr_ptr <= 0;
    end else begin
      if (push_ok) begin
        mem[wr_ptr] <= ursf_pkg::ursf_char_stat_t'(queue_push_word[3:0]);
        wr_ptr      <= (wr_ptr + 1) % DEPTH;
      end
      if (pop_ok) begin
        rd_ptr <= (rd_ptr + 1) % DEPTH;
      end
      count <= count + int'(push_ok) - int'(pop_ok);
    end
  end
  assign queue_full     = (count == DEPTH);
  assign queue_empty    = (count == 0);
  assign queue_pop_stat = mem[rd_ptr];
endmodule

// ### logic/ursf_pin_watch.sv
// change detector for the four pins assigned to one uart
`timescale 1ns/1ps
module ursf_pin_watch #(
  parameter int UART_INDEX = 0,
  parameter int NUM_GPIO   = 16
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  // pins
  input  wire logic [NUM_GPIO-1:0] gpio_in,
  // change pulses, one per assigned pin
  output logic [3:0]               pin_edge
);
  localparam int BASE = UART_INDEX * ursf_pkg::PINS_PER_UART;
  initial begin
    if (BASE + ursf_pkg::PINS_PER_UART > NUM_GPIO) $error("ursf_pin_watch: bad UART_INDEX");
  end

  logic [3:0] seen_reg;
  logic       armed_reg;
  logic [3:0] mine;

  // uart n watches pins 4n to 4n+3
  assign mine = gpio_in[BASE +: ursf_pkg::PINS_PER_UART];

  // first sample after reset only arms, so a strap level is no change
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      seen_reg  <= 4'h0;
      armed_reg <= 1'b0;
    end else begin
      seen_reg  <= mine;
      armed_reg <= 1'b1;
    end
  end

  // any level transition counts
  assign pin_edge = armed_reg ? (mine ^ seen_reg) : 4'h0;
endmodule

// ### logic/ursf_pkg.sv
// package: register map, field positions and carriers for the receive status flags
package ursf_pkg;
  localparam logic [7:0] ADDR_LINE_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_SPCL_ENABLE   = 8'h05;
  localparam logic [7:0] ADDR_SPCL_FLAGS    = 8'h06;
  localparam logic [7:0] ADDR_STS_ENABLE    = 8'h07;
  localparam logic [7:0] ADDR_STS_FLAGS     = 8'h08;
  localparam logic [7:0] ADDR_LSR_ENABLE    = 8'h03;
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  // line status bit positions
  localparam int LS_NOISE   = 5;
  localparam int LS_BREAK   = 4;
  localparam int LS_FRAME   = 3;
  localparam int LS_PARITY  = 2;
  localparam int LS_OVERRUN = 1;
  localparam int LS_STALE   = 0;
  localparam logic [7:0] LS_MASK   = 8'h3F;
  // special character bit positions
  localparam int SC_ADDR    = 5;
  localparam int SC_BREAK   = 4;
  localparam int SC_STOP2   = 3;
  localparam int SC_STOP1   = 2;
  localparam int SC_RESUME2 = 1;
  localparam int SC_RESUME1 = 0;
  localparam logic [7:0] SC_MASK   = 8'h3F;
  // status bit positions
  localparam int ST_CLOCK   = 5;
  localparam logic [7:0] ST_MASK   = 8'h2F;
  localparam logic [3:0] PIN_MASK  = 4'hF;
  localparam int PINS_PER_UART = 4;
  // main interrupt status positions
  localparam int MI_LINE = 0;
  localparam int MI_SPCL = 1;
  localparam int MI_STS  = 2;
  // stale data tick: one count per character-time tick input
  localparam int STALE_WIDTH = 8;

  // per-character receive status that travels with each queue word
  typedef struct packed {
    logic noise;
    logic brk;
    logic frame;
    logic parity;
  } ursf_char_stat_t;

  // one received character event from the receiver
  typedef struct packed {
    logic [7:0]      data;
    logic            ninth;
    logic            parity_bit;
    ursf_char_stat_t stat;
  } ursf_rx_char_t;
endpackage

// ### logic/ursf_stale_timer.sv
// stale data timer on the receive queue
`timescale 1ns/1ps
module ursf_stale_timer #(
  parameter int WIDTH = ursf_pkg::STALE_WIDTH
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // control
  input  wire logic [WIDTH-1:0] limit,
  input  wire logic             char_tick,
  input  wire logic             restart,
  input  wire logic             queue_empty,
  // result
  output logic                  stale
);
  initial begin
    if (WIDTH < 1 || WIDTH > 16) $error("ursf_stale_timer: bad WIDTH");
  end

  logic [WIDTH-1:0] count_reg;

  // reads or writes restart the count; zero limit disables
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else if (restart || queue_empty || limit == '0) begin
      count_reg <= '0;
    end else if (char_tick && count_reg != limit) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // stale once the youngest character outlives the limit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stale <= 1'b0;
    end else if (limit == '0 || restart || queue_empty) begin
      stale <= 1'b0;
    end else if (char_tick && count_reg == limit) begin
      stale <= 1'b1;
    end
  end

  chk_stale_zero_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    limit == '0 |=> !stale) else $error("stale flag with zero limit");
  chk_stale_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    restart |=> !stale) else $error("stale flag survived restart");
endmodule

// ### logic/ursf_status_flags.sv
// receive line status, special character and status interrupt flags of one uart
`timescale 1ns/1ps
// Behaviour
// - noise flag follows last read character
// - long low line queues flagged zero character
// - break flag holds until next character read
// - framing error flag for last read character
// - parity mismatch sets parity error flag
// - multidrop: parity bit shows ninth bit
// - full queue: set overrun, drop new data
// - stale flag after youngest character outlives limit
// - read or write restarts stale counter
// - zero limit disables stale detection
// - enabled line flags raise main bit 0
// - enabled special flags raise main bit 1
// - multidrop address character sets flag bit 5
// - break sets special bit 4, cleared on read
// - flow characters set bits 3..0, cleared on read
// - clock ready reaches main bit 2 when enabled
// - enabled pin change flags reach main bit 2
// - uart n owns pins 4n to 4n+3
// - overrun holds until clean character read; noise, break, framing, parity follow each read
// - clock ready ignores reads, clears when clock_settled drops
// - pin transition sets flag, read clears
module ursf_status_flags #(
  parameter int UART_INDEX  = 0,
  parameter int NUM_GPIO    = 16,
  parameter int STALE_WIDTH = ursf_pkg::STALE_WIDTH
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  // mode and settings from the rest of the uart
  input  wire logic                   multidrop_mode,
  input  wire logic                   special_char_mode,
  input  wire logic                   parity_enable,
  input  wire logic                   parity_odd,
  input  wire logic [STALE_WIDTH-1:0] stale_data_limit,
  input  wire logic                   char_tick,
  // receiver events
  input  wire logic                   rx_valid,
  input  wire ursf_pkg::ursf_rx_char_t rx_char,
  input  wire logic                   rx_break,
  input  wire logic [3:0]             rx_flow_match,
  // receive queue
  input  wire logic                   queue_full,
  input  wire logic                   queue_empty,
  input  wire logic                   queue_pop,
  input  wire ursf_pkg::ursf_char_stat_t queue_pop_stat,
  output logic                        queue_push,
  output logic      [11:0]            queue_push_word,
  // clock and pins
  input  wire logic                   clock_settled,
  input  wire logic [NUM_GPIO-1:0]    gpio_in,
  // summary to the main interrupt status register
  output logic      [2:0]             main_irq_status
);
  initial begin
    if (STALE_WIDTH < 1 || STALE_WIDTH > 16) $error("ursf_status_flags: bad STALE_WIDTH");
  end

  logic [7:0] line_status_irq_enable;
  logic [7:0] special_char_irq_enable;
  logic [7:0] special_char_irq_flags;
  logic [7:0] status_irq_enable;
  logic [3:0] pin_change_flag;
  logic       clock_settled_reg;
  logic       break_char_flag;
  logic       line_noise_flag;
  logic       framing_error_flag;
  logic       parity_error_flag;
  logic       fifo_overflow_flag;
  logic       stale_data_flag;
  logic [3:0] pin_edge;
  logic       rx_par_err;
  logic       push_ok;
  logic [7:0] line_status_reg;
  logic [7:0] status_irq_flags;

  function automatic logic rd_hit(input logic [7:0] a, input logic [7:0] want, input logic rd);
    rd_hit = rd && (a == want);
  endfunction

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] want, input logic wr);
    wr_hit = wr && (a == want);
  endfunction

  // parity check skipped in multidrop mode
  assign rx_par_err = multidrop_mode ? rx_char.ninth :
                      (parity_enable &&
                       ((^rx_char.data) ^ parity_odd ^ rx_char.parity_bit) != 1'b0);
  assign push_ok    = (rx_valid || rx_break) && !queue_full;

  // enable registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      line_status_irq_enable  <= ursf_pkg::RESET_BYTE;
      special_char_irq_enable <= ursf_pkg::RESET_BYTE;
      status_irq_enable       <= ursf_pkg::RESET_BYTE;
    end else begin
      if (wr_hit(reg_addr, ursf_pkg::ADDR_LSR_ENABLE, reg_wr)) begin
        line_status_irq_enable <= reg_wdata & ursf_pkg::LS_MASK;
      end
      if (wr_hit(reg_addr, ursf_pkg::ADDR_SPCL_ENABLE, reg_wr)) begin
        special_char_irq_enable <= reg_wdata & ursf_pkg::SC_MASK;
      end
      if (wr_hit(reg_addr, ursf_pkg::ADDR_STS_ENABLE, reg_wr)) begin
        status_irq_enable <= reg_wdata & ursf_pkg::ST_MASK;
      end
    end
  end

  // queue write: break pushes all zeros tagged; full queue drops the word
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      queue_push      <= 1'b0;
      queue_push_word <= 12'h000;
    end else begin
      queue_push <= push_ok;
      if (rx_break) begin
        queue_push_word <= {8'h00, 4'b0100};
      end else begin
        queue_push_word <= {rx_char.data, rx_char.stat.noise, 1'b0,
                            rx_char.stat.frame, rx_par_err};
      end
    end
  end

  // per-character flags describe the last word popped
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      line_noise_flag    <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
    end else if (queue_pop) begin
      line_noise_flag    <= queue_pop_stat.noise;
      framing_error_flag <= queue_pop_stat.frame;
      parity_error_flag  <= queue_pop_stat.parity;
    end
  end

  // break sticks until the word after the break word is read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      break_char_flag <= 1'b0;
    end else if (queue_pop) begin
      break_char_flag <= queue_pop_stat.brk;
    end
  end

  // overrun sets on a drop and holds until a clean character is read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fifo_overflow_flag <= 1'b0;
    end else if ((rx_valid || rx_break) && queue_full) begin
      fifo_overflow_flag <= 1'b1;
    end else if (queue_pop && queue_pop_stat == '0) begin
      fifo_overflow_flag <= 1'b0;
    end
  end

  // stale data detection feeds line status bit 0
  ursf_stale_timer #(
    .WIDTH (STALE_WIDTH)
  ) u_stale (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .limit       (stale_data_limit),
    .char_tick   (char_tick),
    .restart     (queue_pop || queue_push),
    .queue_empty (queue_empty),
    .stale       (stale_data_flag)
  );

  // only this uart's own four pins are watched
  ursf_pin_watch #(
    .UART_INDEX (UART_INDEX),
    .NUM_GPIO   (NUM_GPIO)
  ) u_pins (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .gpio_in  (gpio_in),
    .pin_edge (pin_edge)
  );

  // special character flags; a set in the read cycle wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      special_char_irq_flags <= ursf_pkg::RESET_BYTE;
    end else begin
      special_char_irq_flags <=
        (rd_hit(reg_addr, ursf_pkg::ADDR_SPCL_FLAGS, reg_rd) ? 8'h00 : special_char_irq_flags)
        | {2'b00,
           rx_valid && multidrop_mode && rx_char.ninth,
           rx_break,
           rx_valid && special_char_mode ? rx_flow_match : 4'h0};
    end
  end

  // pin change flags clear on read, set wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_change_flag <= 4'h0;
    end else begin
      pin_change_flag <=
        (rd_hit(reg_addr, ursf_pkg::ADDR_STS_FLAGS, reg_rd) ? 4'h0 : pin_change_flag) | pin_edge;
    end
  end

  // clock ready follows the clock, never the read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clock_settled_reg <= 1'b0;
    end else begin
      clock_settled_reg <= clock_settled;
    end
  end

  assign line_status_reg  = {2'b00, line_noise_flag, break_char_flag, framing_error_flag,
                             parity_error_flag, fifo_overflow_flag, stale_data_flag};
  assign status_irq_flags = {2'b00, clock_settled_reg, 1'b0, pin_change_flag};

  // summary bits gated by their enables
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      main_irq_status <= 3'b000;
    end else begin
      main_irq_status[ursf_pkg::MI_LINE] <= |(line_status_reg & line_status_irq_enable);
      main_irq_status[ursf_pkg::MI_SPCL] <=
        |(special_char_irq_flags & special_char_irq_enable);
      main_irq_status[ursf_pkg::MI_STS]  <= |(status_irq_flags & status_irq_enable);
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= ursf_pkg::RESET_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        ursf_pkg::ADDR_LSR_ENABLE:   reg_rdata <= line_status_irq_enable;
        ursf_pkg::ADDR_LINE_STATUS:  reg_rdata <= line_status_reg;
        ursf_pkg::ADDR_SPCL_ENABLE:  reg_rdata <= special_char_irq_enable;
        ursf_pkg::ADDR_SPCL_FLAGS:   reg_rdata <= special_char_irq_flags;
        ursf_pkg::ADDR_STS_ENABLE:   reg_rdata <= status_irq_enable;
        ursf_pkg::ADDR_STS_FLAGS:    reg_rdata <= status_irq_flags;
        default:                     reg_rdata <= 8'h00;
      endcase
    end
  end

  chk_overrun_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
    rx_valid && queue_full |=> !queue_push && fifo_overflow_flag)
    else $error("word pushed into full queue");
  chk_break_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    rx_break && !queue_full |=> queue_push && queue_push_word[11:4] == 8'h00
    && queue_push_word[2]) else $error("break word wrong");
  chk_break_spcl: assert property (@(posedge clk_sys) disable iff (!nrst)
    rx_break |=> special_char_irq_flags[ursf_pkg::SC_BREAK])
    else $error("break flag not set");
  chk_addr_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
    rx_valid && multidrop_mode && rx_char.ninth |=> special_char_irq_flags[ursf_pkg::SC_ADDR])
    else $error("address flag not set");
  chk_flow_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    !special_char_mode && !rd_hit(reg_addr, ursf_pkg::ADDR_SPCL_FLAGS, reg_rd)
    |=> special_char_irq_flags[3:0] == $past(special_char_irq_flags[3:0]))
    else $error("flow flag set while detection off");
  chk_spcl_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_hit(reg_addr, ursf_pkg::ADDR_SPCL_FLAGS, reg_rd) && !rx_valid && !rx_break
    |=> special_char_irq_flags == 8'h00) else $error("special flags kept after read");
  chk_spcl_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    special_char_irq_enable == 8'h00 |=> !main_irq_status[ursf_pkg::MI_SPCL])
    else $error("special summary unmasked");
  chk_line_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    line_status_irq_enable == 8'h00 |=> !main_irq_status[ursf_pkg::MI_LINE])
    else $error("line summary unmasked");
  chk_clock_route: assert property (@(posedge clk_sys) disable iff (!nrst)
    clock_settled_reg && status_irq_enable[ursf_pkg::ST_CLOCK]
    |=> main_irq_status[ursf_pkg::MI_STS]) else $error("clock ready not routed");
  chk_clock_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    clock_settled && rd_hit(reg_addr, ursf_pkg::ADDR_STS_FLAGS, reg_rd)
    |=> status_irq_flags[ursf_pkg::ST_CLOCK])
    else $error("clock ready cleared by read");
  chk_pin_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    pin_edge != 4'h0 |=> (pin_change_flag & $past(pin_edge)) == $past(pin_edge))
    else $error("pin change lost");
  chk_noise_pop: assert property (@(posedge clk_sys) disable iff (!nrst)
    queue_pop |=> line_noise_flag == $past(queue_pop_stat.noise))
    else $error("noise flag not from read word");
  chk_break_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    break_char_flag && !queue_pop |=> break_char_flag)
    else $error("break flag dropped without read");
  chk_overrun_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    fifo_overflow_flag && !queue_pop |=> fifo_overflow_flag)
    else $error("overrun flag dropped without read");
  chk_ninth_shown: assert property (@(posedge clk_sys) disable iff (!nrst)
    rx_valid && !rx_break && multidrop_mode |=> queue_push_word[0] == $past(rx_char.ninth))
    else $error("ninth bit not in parity position");
endmodule
